/* File: src/dpc_params.svh */
// Purpose: Constants for the strobe phase capture block
// Assumes: 100 MHz system clock
// Notes: Times in their own units, cycle counts derived
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

// ----------------------------------------
// Structure
// ----------------------------------------
`define DPC_NUM_EDGE 2
`define DPC_NUM_DQS 10
`define DPC_DQ_W 8
`define DPC_MAX_DLY 32
`define DPC_DLY_W 5
`define DPC_CNT_W 8

// ----------------------------------------
// Phase reference
// ----------------------------------------
`define DPC_FULL_TURN 360
`define DPC_LOCK_REF_CYC 256
`define DPC_PHASE_TOP 90
`define DPC_PHASE_BOT 72

// ----------------------------------------
// Clock rates (MHz) and derived counts
// ----------------------------------------
`define DPC_SYS_MHZ 100
`define DPC_DDR_MAX_MHZ 200
`define DPC_QDR_MAX_MHZ 167
// Least legal reference period in system cycles, rounded up, at least one
`define DPC_MIN_PER_CYC ((`DPC_SYS_MHZ + `DPC_DDR_MAX_MHZ - 1) / `DPC_DDR_MAX_MHZ)

`endif

/* File: src/dpc_pkg.sv */
// Purpose: Types shared by the strobe phase capture block
// Assumes: Constants come from dpc_params.svh
// Notes: Types only
package dpc_pkg;

	// Phase shift in degrees
	typedef logic [8:0] dpc_deg_t;

	// Phase reference sequencing
	typedef enum logic [1:0] {
		DPC_REF_IDLE,
		DPC_REF_MEAS,
		DPC_REF_LOCK
	} dpc_ref_e;

endpackage : dpc_pkg

/* File: src/dpc_phase_ref.sv */
// Purpose: Phase-shift reference, turns a reference clock into a strobe delay
// Assumes: ref_lvl already synchronised to clk_sys
// Notes: Delay in system cycles, common to all strobes of one edge
`timescale 1ns/1ns
`include "dpc_params.svh"

module dpc_phase_ref #(
	parameter int DLY_W = `DPC_DLY_W,
	parameter int CNT_W = `DPC_CNT_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Reference level and shift
	input wire logic ref_lvl,
	input wire dpc_pkg::dpc_deg_t phase_deg,
	// Result
	output logic [DLY_W-1:0] dly,
	output logic locked
);
	import dpc_pkg::*;

	typedef struct packed {
		logic prev;
		logic [CNT_W-1:0] cnt;
		logic [8:0] nref;
		dpc_ref_e fsm;
		logic [DLY_W-1:0] dly;
		logic locked;
	} dpr_state_s;

	dpr_state_s s_q;
	dpr_state_s s_d;
	logic [CNT_W+8:0] prod;
	logic [CNT_W+8:0] quo;

	// ----------------------------------------
	// Period measure and lock
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.prev = ref_lvl;
		prod = {9'h000, s_q.cnt} * {{CNT_W{1'b0}}, phase_deg};
		quo = prod / (CNT_W+9)'(`DPC_FULL_TURN);
		if (ref_lvl && !s_q.prev) begin
			s_d.cnt = CNT_W'(1);
			if (s_q.nref != 9'h1FF) begin
				s_d.nref = s_q.nref + 9'h001;
			end
			case (s_q.fsm)
				DPC_REF_IDLE: begin
					s_d.fsm = DPC_REF_MEAS;
				end
				DPC_REF_MEAS, DPC_REF_LOCK: begin
					if (s_q.cnt >= CNT_W'(`DPC_MIN_PER_CYC)) begin
						s_d.dly = (quo > (CNT_W+9)'(`DPC_MAX_DLY - 1)) ?
							DLY_W'(`DPC_MAX_DLY - 1) : quo[DLY_W-1:0];
						s_d.fsm = DPC_REF_LOCK;
						s_d.locked = 1'b1;
					end
				end
				default: begin
					s_d.fsm = DPC_REF_IDLE;
				end
			endcase
			if (s_q.nref >= 9'(`DPC_LOCK_REF_CYC - 1)) begin
				s_d.locked = 1'b1;
			end
		end else if (s_q.cnt != {CNT_W{1'b1}}) begin
			s_d.cnt = s_q.cnt + CNT_W'(1);
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{prev: 1'b0, cnt: '0, nref: 9'h000, fsm: DPC_REF_IDLE,
				dly: '0, locked: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign dly = s_q.dly;
	assign locked = s_q.locked;

endmodule : dpc_phase_ref

/* File: src/dpc_capture.sv */
// Purpose: DDR strobe phase capture for two device edges with output path
// Assumes: Pins and reference clocks sampled by clk_sys through two flops
// Notes: One phase reference per edge; read words pass a two-entry buffer
//
// Operation
// - Output registers load only while their clock enable is high, else they hold.
// - Data lines are grouped under one strobe in widths of 8, 16 or 32 bits.
// - Each strobe passes its own delay that moves it into the data valid window.
// - The delayed strobe alone clocks the data capture of its own group.
// - Each edge has its own phase reference run by a clock at strobe frequency.
// - One reference sets one common shift for all ten strobes of its edge.
// - A reference sets its phase within 256 of its reference clock cycles.
// - In side-bank mode the read strobe is ignored and data is captured without it.
// - Strobe bank DDR interfaces run no faster than 200 MHz.
// - QDR and QDRII interfaces run no faster than 167 MHz.
// - Each data pin has six registers and one input latch for memory use.
// - A latch holds the high-phase bit so both bits appear on one edge.
// - Two rising-edge output registers are muxed onto the pin by clock level.
// - The output enable changes only at the clock falling edge.
`timescale 1ns/1ns
`include "dpc_params.svh"

module dpc_capture #(
	parameter int NE = `DPC_NUM_EDGE,
	parameter int NG = `DPC_NUM_DQS,
	parameter int DQ_W = `DPC_DQ_W,
	parameter int MAXD = `DPC_MAX_DLY
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Reference clocks and setup per edge
	input wire logic [NE-1:0] ref_clk,
	input wire dpc_pkg::dpc_deg_t [NE-1:0] phase_deg,
	input wire logic [NE-1:0] side_mode,
	// Memory pins
	input wire logic [NE-1:0][NG-1:0] dqs_i,
	input wire logic [NE-1:0][NG*DQ_W-1:0] dq_i,
	output logic [NE-1:0][NG*DQ_W-1:0] dq_o,
	output logic [NE-1:0] dq_oe,
	// Write side
	input wire logic [NE-1:0][NG*DQ_W-1:0] wr_hi,
	input wire logic [NE-1:0][NG*DQ_W-1:0] wr_lo,
	input wire logic [NE-1:0] wr_oe,
	input wire logic [NE-1:0] wr_ce,
	// Read side
	output logic [NE-1:0] rd_valid,
	output logic [NE-1:0][2*NG*DQ_W-1:0] rd_data,
	input wire logic [NE-1:0] rd_ready,
	output logic [NE-1:0] rd_room,
	// Status
	output logic [NE-1:0] ref_locked
);
	import dpc_pkg::*;

	localparam int W = NG * DQ_W;
	localparam int DW = $clog2(MAXD);

	typedef struct packed {
		logic [NE-1:0] ref_s1;
		logic [NE-1:0] ref_s2;
		logic [NE-1:0] ref_p;
		logic [NE-1:0][NG-1:0] dqs_s1;
		logic [NE-1:0][NG-1:0] dqs_s2;
		logic [NE-1:0][W-1:0] dq_s1;
		logic [NE-1:0][W-1:0] dq_s2;
		logic [NE-1:0][NG-1:0][MAXD-1:0] hist;
		logic [NE-1:0][NG-1:0] dqd_p;
		logic [NE-1:0][W-1:0] lat;
		logic [NE-1:0][2*W-1:0] wrd;
		logic [NE-1:0][NG-1:0] got;
		logic [NE-1:0][1:0][2*W-1:0] bufw;
		logic [NE-1:0][1:0] bufv;
		logic [NE-1:0] room;
		logic [NE-1:0][W-1:0] out_hi;
		logic [NE-1:0][W-1:0] out_lo;
		logic [NE-1:0][W-1:0] pin;
		logic [NE-1:0] oe;
		logic [NE-1:0] locked;
	} dpc_state_s;

	dpc_state_s s_q;
	dpc_state_s s_d;
	logic [NE-1:0][DW-1:0] dly;
	logic [NE-1:0] lock_w;

	// ----------------------------------------
	// Phase references, one per edge
	// ----------------------------------------
	// independent reference per edge
	for (genvar e = 0; e < NE; e++) begin : g_ref
		dpc_phase_ref #(
			.DLY_W(DW),
			.CNT_W(`DPC_CNT_W)
		) u_ref (
			.clk_sys(clk_sys),
			.rstn(rstn),
			.ref_lvl(s_q.ref_s2[e]),
			.phase_deg(phase_deg[e]),
			.dly(dly[e]),
			.locked(lock_w[e])
		);
	end

	function automatic logic dpc_width_ok(input int w);
		dpc_width_ok = (w == 8) || (w == 16) || (w == 32);
	endfunction : dpc_width_ok

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic d;
		logic cap_en;
		logic full_word;
		logic push;
		logic [2*W-1:0] nw;
		d = 1'b0;
		cap_en = 1'b0;
		full_word = 1'b0;
		push = 1'b0;
		nw = '0;
		s_d = s_q;
		// Two-flop input synchronisers
		s_d.ref_s1 = ref_clk;
		s_d.ref_s2 = s_q.ref_s1;
		s_d.ref_p = s_q.ref_s2;
		s_d.dqs_s1 = dqs_i;
		s_d.dqs_s2 = s_q.dqs_s1;
		s_d.dq_s1 = dq_i;
		s_d.dq_s2 = s_q.dq_s1;
		s_d.locked = lock_w;
		for (int e = 0; e < NE; e++) begin
			cap_en = side_mode[e] || lock_w[e];
			for (int g = 0; g < NG; g++) begin
				s_d.hist[e][g] = {s_q.hist[e][g][MAXD-2:0], s_q.dqs_s2[e][g]};
				if (side_mode[e]) begin
					d = s_q.ref_s2[e];
				end else begin
					d = s_q.hist[e][g][dly[e]];
				end
				s_d.dqd_p[e][g] = d;
				if (cap_en && d && !s_q.dqd_p[e][g]) begin
					s_d.lat[e][g*DQ_W +: DQ_W] = s_q.dq_s2[e][g*DQ_W +: DQ_W];
				end
				if (cap_en && !d && s_q.dqd_p[e][g]) begin
					// rising and falling bits, one edge
					s_d.wrd[e][g*2*DQ_W +: 2*DQ_W] =
						{s_q.dq_s2[e][g*DQ_W +: DQ_W], s_q.lat[e][g*DQ_W +: DQ_W]};
					s_d.got[e][g] = 1'b1;
				end
			end
			// Word complete once every group has both bits
			full_word = &s_d.got[e];
			push = full_word && dpc_width_ok(DQ_W);
			nw = s_d.wrd[e];
			if (full_word) begin
				s_d.got[e] = '0;
			end
			// Two-entry buffer, head always in slot 0
			if (rd_ready[e] && s_q.bufv[e][0]) begin
				s_d.bufw[e][0] = s_q.bufw[e][1];
				s_d.bufv[e][0] = s_q.bufv[e][1];
				s_d.bufv[e][1] = 1'b0;
			end
			if (push && !s_d.bufv[e][0]) begin
				s_d.bufw[e][0] = nw;
				s_d.bufv[e][0] = 1'b1;
			end else if (push && !s_d.bufv[e][1]) begin
				s_d.bufw[e][1] = nw;
				s_d.bufv[e][1] = 1'b1;
			end
			s_d.room[e] = !s_d.bufv[e][1];
			if (wr_ce[e] && s_q.ref_s2[e] && !s_q.ref_p[e]) begin
				s_d.out_hi[e] = wr_hi[e];
				s_d.out_lo[e] = wr_lo[e];
			end
			s_d.pin[e] = s_q.ref_s2[e] ? s_d.out_hi[e] : s_d.out_lo[e];
			if (wr_ce[e] && !s_q.ref_s2[e] && s_q.ref_p[e]) begin
				s_d.oe[e] = wr_oe[e];
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs, all from registers
	for (genvar e = 0; e < NE; e++) begin : g_out
		assign rd_data[e] = s_q.bufw[e][0];
		assign rd_valid[e] = s_q.bufv[e][0];
	end
	assign rd_room = s_q.room;
	assign dq_o = s_q.pin;
	assign dq_oe = s_q.oe;
	assign ref_locked = s_q.locked;

endmodule : dpc_capture

/* File: test/dpc_capture_properties.sv */
// Purpose: Port checks on dpc_capture
// Assumes: Reference pins seen two or three cycles late
// Notes: Edge 0 watched
`timescale 1ns/1ns
module dpc_capture_props #(
	parameter int NE = 2,
	parameter int NG = 10,
	parameter int DQ_W = 8
) (
	// Clock, reset, setup
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [NE-1:0] ref_clk,
	input wire logic [NE-1:0] side_mode,
	// Outputs and their controls
	input wire logic [NE-1:0] wr_ce,
	input wire logic [NE-1:0][NG*DQ_W-1:0] dq_o,
	input wire logic [NE-1:0] dq_oe,
	input wire logic [NE-1:0] rd_valid,
	input wire logic [NE-1:0][2*NG*DQ_W-1:0] rd_data,
	input wire logic [NE-1:0] rd_ready,
	input wire logic [NE-1:0] rd_room,
	input wire logic [NE-1:0] ref_locked
);
	logic ref_q;
	logic [9:0] rises_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Count reference pin rises
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ref_q <= 1'b0;
			rises_q <= '0;
		end else begin
			ref_q <= ref_clk[0];
			if (ref_clk[0] && !ref_q && rises_q != 10'h3FF)
				rises_q <= rises_q + 10'h001;
		end
	end
	// Reference edge seen a few cycles back
	sequence s_rose; $past(ref_clk[0], 2) && !$past(ref_clk[0], 5); endsequence
	sequence s_fell; !$past(ref_clk[0], 2) && $past(ref_clk[0], 5); endsequence
	property p_quiet; $rose(rstn) |-> rd_valid == '0 && dq_oe == '0 && ref_locked == '0; endproperty
	property p_ce_hold; (!wr_ce[0])[*4] |-> $stable(dq_oe[0]); endproperty
	property p_oe_fall; $changed(dq_oe[0]) |-> s_fell; endproperty
	property p_out_mux; $changed(dq_o[0]) |-> (s_rose or s_fell); endproperty
	property p_lock; rises_q > 10'h104 |-> ref_locked[0]; endproperty
	property p_no_early; $rose(rd_valid[0]) && !side_mode[0] |-> $past(ref_locked[0]); endproperty
	property p_head; rd_valid[0] && !rd_ready[0] |=> rd_valid[0] && $stable(rd_data[0]); endproperty
	property p_room; $fell(rd_room[0]) |-> rd_valid[0]; endproperty
	a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
	a_ce_hold: assert property (p_ce_hold) else $error("enable moved with ce low");
	a_oe_fall: assert property (p_oe_fall) else $error("enable moved off falling edge");
	a_out_mux: assert property (p_out_mux) else $error("output moved off ref edge");
	a_lock: assert property (p_lock) else $error("no lock in time");
	a_no_early: assert property (p_no_early) else $error("word before lock");
	a_head: assert property (p_head) else $error("head word lost");
	a_room: assert property (p_room) else $error("room low while empty");
endmodule : dpc_capture_props

bind dpc_capture dpc_capture_props #(.NE(NE), .NG(NG), .DQ_W(DQ_W)) u_dpc_capture_props (
	.clk_sys(clk_sys), .rstn(rstn), .ref_clk(ref_clk), .side_mode(side_mode), .wr_ce(wr_ce),
	.dq_o(dq_o), .dq_oe(dq_oe), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
	.rd_room(rd_room), .ref_locked(ref_locked));

/* File: test/dpc_mem_model.sv */
// Purpose: Memory chip read side for one edge
// Assumes: Strobe at reference clock rate
// Notes: Released data shows the inverse
`timescale 1ns/1ns
module dpc_mem_model #(
	parameter int NG = 2,
	parameter int DQ_W = 8
) (
	// Control
	input wire logic ref_clk,
	input wire logic go,
	input wire logic slow,
	input wire logic mute,
	input wire logic [NG*DQ_W-1:0] rise_w,
	input wire logic [NG*DQ_W-1:0] fall_w,
	// Pins
	output logic [NG-1:0] dqs,
	output logic [NG*DQ_W-1:0] dq
);
	// ----------------
	// Read frames
	// ----------------
	initial begin
		dqs = '0;
		dq = '0;
		forever begin
			@(posedge go);
			@(posedge ref_clk);
			if (slow)
				@(posedge ref_clk);
			dq = rise_w;
			dqs = {NG{!mute}};
			@(negedge ref_clk);
			dq = fall_w;
			dqs = '0;
			@(posedge ref_clk);
			dq = ~fall_w;
		end
	end
endmodule : dpc_mem_model

/* File: test/dpc_capture_bench.sv */
// Purpose: Self-checking bench for dpc_capture
// Assumes: Two groups of eight lines per edge
// Notes: Reference clocks 125 ns
`timescale 1ns/1ns
module dpc_capture_bench;
	import dpc_pkg::*;
	localparam int W = 16;
	logic clk_sys, rstn, slow, mute;
	logic [1:0] ref_clk, side_mode, dq_oe, wr_oe, wr_ce, rd_valid, rd_ready, rd_room, ref_locked, go;
	dpc_deg_t [1:0] phase_deg;
	wire [1:0][1:0] dqs_i;
	wire [1:0][W-1:0] dq_i, mdq;
	logic [1:0][W-1:0] dq_o, wr_hi, wr_lo, rw, fw;
	logic [1:0][2*W-1:0] rd_data;
	int num_errors, samples_checked;
	dpc_capture #(.NG(2), .DQ_W(8)) u_dpc_capture (.clk_sys(clk_sys), .rstn(rstn),
		.ref_clk(ref_clk), .phase_deg(phase_deg), .side_mode(side_mode), .dqs_i(dqs_i),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .wr_hi(wr_hi), .wr_lo(wr_lo), .wr_oe(wr_oe),
		.wr_ce(wr_ce), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
		.rd_room(rd_room), .ref_locked(ref_locked));
	// Memory per edge, pin level from enables
	for (genvar e = 0; e < 2; e++) begin : g_mem
		dpc_mem_model #(.NG(2), .DQ_W(8)) u_dpc_mem_model (.ref_clk(ref_clk[e]), .go(go[e]),
			.slow(slow), .mute(mute), .rise_w(rw[e]), .fall_w(fw[e]), .dqs(dqs_i[e]), .dq(mdq[e]));
		assign dq_i[e] = dq_oe[e] ? dq_o[e] : mdq[e];
	end
	// Clocks; reference far below limit
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		ref_clk = 2'h0;
		// 125 ns period, edges kept off the system clock edges
		fork
			begin
				#1;
				forever begin
					ref_clk[0] = 1'b1;
					#62;
					ref_clk[0] = 1'b0;
					#63;
				end
			end
			begin
				#42;
				forever begin
					ref_clk[1] = 1'b1;
					#62;
					ref_clk[1] = 1'b0;
					#63;
				end
			end
		join
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	function automatic logic [2*W-1:0] word(input logic [W-1:0] r, input logic [W-1:0] f);
		return {f[15:8], r[15:8], f[7:0], r[7:0]};
	endfunction : word
	task automatic frame(input int e, input logic [W-1:0] r, input logic [W-1:0] f);
		rw[e] <= r;
		fw[e] <= f;
		go[e] <= 1'b1;
		@(posedge clk_sys);
		go[e] <= 1'b0;
		repeat (3 + slow) @(posedge ref_clk[e]);
		@(posedge clk_sys);
	endtask : frame
	task automatic pop(input int e, input logic [2*W-1:0] exp);
		@(negedge clk_sys);
		check(32'(rd_valid[e]), 32'h1);
		check(rd_data[e], exp);
		@(posedge clk_sys);
		rd_ready[e] <= 1'b1;
		@(posedge clk_sys);
		rd_ready[e] <= 1'b0;
	endtask : pop
	task automatic t_lock();
		for (int i = 0; i < 4000 && ref_locked !== 2'h3; i++)
			@(posedge clk_sys);
		@(negedge clk_sys);
		check(32'(ref_locked), 32'h3);
		check(32'(rd_valid), 32'h0);
	endtask : t_lock
	task automatic t_read();
		frame(0, 16'hC35A, 16'h5AC3);
		pop(0, word(16'hC35A, 16'h5AC3));
		frame(1, 16'h96E1, 16'h1E69);
		pop(1, word(16'h96E1, 16'h1E69));
	endtask : t_read
	task automatic t_buffer();
		frame(0, 16'h0F1E, 16'hE1F0);
		slow <= 1'b1;
		frame(0, 16'h2D3C, 16'hD2C3);
		slow <= 1'b0;
		check(32'(rd_room[0]), 32'h0);
		frame(0, 16'h4B5A, 16'hB4A5);
		pop(0, word(16'h0F1E, 16'hE1F0));
		pop(0, word(16'h2D3C, 16'hD2C3));
		@(negedge clk_sys);
		check(32'(rd_valid[0]), 32'h0);
	endtask : t_buffer
	task automatic t_side();
		// Enter side mode while sampled reference is low
		@(negedge ref_clk[1]);
		repeat (4) @(posedge clk_sys);
		side_mode[1] <= 1'b1;
		mute <= 1'b1;
		frame(1, 16'h7788, 16'h8877);
		pop(1, word(16'h7788, 16'h8877));
		side_mode[1] <= 1'b0;
		mute <= 1'b0;
	endtask : t_side
	task automatic phases(input logic [W-1:0] hi, input logic [W-1:0] lo, input logic oe);
		@(posedge ref_clk[0]);
		repeat (6) @(negedge clk_sys);
		check(dq_o[0], hi);
		@(negedge ref_clk[0]);
		repeat (6) @(negedge clk_sys);
		check(dq_o[0], lo);
		check(32'(dq_oe[0]), 32'(oe));
	endtask : phases
	task automatic t_write();
		@(posedge clk_sys);
		{wr_hi[0], wr_lo[0], wr_oe[0], wr_ce[0]} <= {16'hA5C3, 16'h3C5A, 2'h3};
		repeat (2) phases(16'hA5C3, 16'h3C5A, 1'b1);
		@(posedge clk_sys);
		{wr_hi[0], wr_lo[0], wr_oe[0], wr_ce[0]} <= {16'h1111, 16'h2222, 2'h0};
		repeat (2) phases(16'hA5C3, 16'h3C5A, 1'b1);
	endtask : t_write
	// Watchdog on a hung run
	initial begin
		#300000;
		num_errors++;
		complete_run();
	end
	// Main sequence
	initial begin
		{rstn, slow, mute, side_mode, go, wr_oe, wr_ce, rd_ready} = '0;
		{wr_hi, wr_lo, rw, fw} = '0;
		phase_deg = {9'h048, 9'h05A};
		num_errors = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk_sys);
		check(32'({rd_valid, dq_oe, ref_locked}), 32'h0);
		rstn <= 1'b1;
		t_lock();
		t_read();
		t_buffer();
		t_side();
		t_write();
		// Run past the lock bound so the lock property is exercised
		repeat (262) @(posedge ref_clk[0]);
		complete_run();
	end
endmodule : dpc_capture_bench
